// File: rtl/link_pattern_gen.sv
/*
  link pattern generator: drives test patterns across the frame link.
  assumes start/stop come from logic on clk_sys_i; receivers sample on
  the falling edge of link_clk_o.
*/
`timescale 1ns/1ps
`include "link_test_defines.svh"

module link_pattern_gen
  import link_test_pkg::*;
#(
  parameter int unsigned HALF_CYC = `LT_HALF_CYC
) (
  input  wire logic                 clk_sys_i,
  input  wire logic                 rst_n_i,
  input  wire logic                 start_i,
  input  wire logic                 repeat_i,
  input  wire logic                 stop_i,
  output logic                      link_clk_o,
  output logic [`LT_BUS_W-1:0]      data_o,
  output logic [`LT_BUS_W-1:0]      addr_o,
  output logic [`LT_STB_W-1:0]      stb_o,
  output logic                      busy_o
);

  run_state_e  state_q;
  logic        rep_q;
  logic        rise;
  logic        clk_lvl;
  logic        first_q;
  link_word_s  word_q;

  // =====================================================================
  // link clock
  link_clk_div #(
    .HALF_CYC (HALF_CYC)
  ) u_div (
    .clk_sys_i  (clk_sys_i),
    .rst_n_i    (rst_n_i),
    .run_i      (state_q == ST_RUN),
    .link_clk_o (clk_lvl),
    .rise_o     (rise)
  );

  // =====================================================================
  // run control
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= ST_IDLE;
      rep_q   <= 1'b0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (start_i) begin
            state_q <= ST_RUN;
            rep_q   <= repeat_i;
          end
        end
        ST_RUN: begin
          if (stop_i) begin
            state_q <= ST_STOP;
          end else if (rise && !rep_q &&
                       word_q.stb == {1'b0, {(`LT_STB_W-1){1'b1}}}) begin
            // single pass ends after one full strobe sweep
            state_q <= ST_STOP;
          end
        end
        ST_STOP: begin
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // =====================================================================
  // pattern step: changes one system cycle after the link clock rising edge so it is
  // settled a half period less one system cycle before the falling edge where it is sampled
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      first_q     <= 1'b1;
      word_q.data <= `LT_PAT_A;
      word_q.addr <= `LT_PAT_A;
      word_q.stb  <= `LT_STB_FIRST;
    end else if (state_q != ST_RUN) begin
      first_q     <= 1'b1;
      word_q.data <= `LT_PAT_A;
      word_q.addr <= `LT_PAT_A;
      word_q.stb  <= `LT_STB_FIRST;
    end else if (rise && first_q) begin
      // opening word has no falling edge yet; keep it one more period
      first_q <= 1'b0;
    end else if (rise) begin
      word_q.data <= (word_q.data == `LT_PAT_A) ? `LT_PAT_B
                                               : `LT_PAT_A;
      word_q.addr <= (word_q.addr == `LT_PAT_A) ? `LT_PAT_B
                                               : `LT_PAT_A;
      if (word_q.stb[`LT_STB_W-1] == 1'b0) begin
        word_q.stb <= `LT_STB_FIRST;
      end else begin
        word_q.stb <= {word_q.stb[`LT_STB_W-2:0], 1'b1};
      end
    end
  end

  // =====================================================================
  // outputs registered; idle shows all strobes high
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      link_clk_o <= 1'b0;
      data_o     <= '0;
      addr_o     <= '0;
      stb_o      <= `LT_STB_IDLE;
      busy_o     <= 1'b0;
    end else begin
      link_clk_o <= clk_lvl;
      busy_o     <= (state_q == ST_RUN);
      if (state_q == ST_RUN) begin
        data_o <= word_q.data;
        addr_o <= word_q.addr;
        stb_o  <= word_q.stb;
      end else begin
        data_o <= '0;
        addr_o <= '0;
        stb_o  <= `LT_STB_IDLE;
      end
    end
  end

endmodule

// File: rtl/link_test_defines.svh
/*
  timing counts, pattern values and widths of the link pattern generator.
  assumes inclusion by bare name from the package and rtl modules.
*/
`ifndef LINK_TEST_DEFINES_SVH
`define LINK_TEST_DEFINES_SVH

// =====================================================================
// widths
`define LT_BUS_W        8
`define LT_STB_W        5

// =====================================================================
// pattern values
`define LT_PAT_A        8'hAA
`define LT_PAT_B        8'h55
`define LT_STB_FIRST    5'h1E
`define LT_STB_IDLE     5'h1F

// =====================================================================
// link clock timing: half period in ns at the 5 ns system clock
`define LT_SYS_PERIOD_NS 5
`define LT_HALF_NS       50
`define LT_HALF_CYC      ((`LT_HALF_NS + `LT_SYS_PERIOD_NS - 1) / \
                          `LT_SYS_PERIOD_NS)

`endif

// File: rtl/link_test_pkg.sv
/*
  types shared by the link pattern generator.
  assumes link_test_defines.svh is on the include path.
*/
`include "link_test_defines.svh"

package link_test_pkg;

  // =====================================================================
  // one transfer on the link
  typedef struct packed {
    logic [`LT_BUS_W-1:0] data;
    logic [`LT_BUS_W-1:0] addr;
    logic [`LT_STB_W-1:0] stb;
  } link_word_s;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN  = 2'b01,
    ST_STOP = 2'b10
  } run_state_e;

endpackage

// File: rtl/link_clk_div.sv
/*
  divider making the link clock level and a one-cycle pulse in the cycle
  that the level rises. assumes one system clock and async reset.
*/
`timescale 1ns/1ps

module link_clk_div #(
  parameter int unsigned HALF_CYC = 10
) (
  input  wire logic clk_sys_i,
  input  wire logic rst_n_i,
  input  wire logic run_i,
  output logic      link_clk_o,
  output logic      rise_o
);

  localparam int unsigned CW = $clog2(HALF_CYC + 1);

  logic [CW-1:0] cnt_q;

  // =====================================================================
  // divider: the clock stands low outside a run
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q      <= '0;
      link_clk_o <= 1'b0;
      rise_o     <= 1'b0;
    end else if (!run_i) begin
      cnt_q      <= '0;
      link_clk_o <= 1'b0;
      rise_o     <= 1'b0;
    end else if (cnt_q == CW'(HALF_CYC - 1)) begin
      cnt_q      <= '0;
      link_clk_o <= ~link_clk_o;
      rise_o     <= ~link_clk_o;
    end else begin
      cnt_q  <= cnt_q + CW'(1);
      rise_o <= 1'b0;
    end
  end

endmodule

// File: tb/link_pattern_gen_assertions.sv
/* checker on the pattern generator ports.
   assumes one clock and the async active-low reset. */
`timescale 1ns/1ps
`include "link_test_defines.svh"
// =====================================================
// checker
module link_pattern_gen_chk (
  input wire logic                 clk_sys_i,
  input wire logic                 rst_n_i,
  input wire logic                 stop_i,
  input wire logic                 link_clk_o,
  input wire logic [`LT_BUS_W-1:0] data_o,
  input wire logic [`LT_BUS_W-1:0] addr_o,
  input wire logic [`LT_STB_W-1:0] stb_o,
  input wire logic                 busy_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  chk_addr_same: assert property (busy_o |-> addr_o == data_o)
    else $error("address differs from data");
  chk_byte_vals: assert property (busy_o |->
    data_o inside {8'hAA, 8'h55}) else $error("data outside pattern");
  chk_byte_alt: assert property (busy_o && $past(busy_o)
    && $changed(data_o) |-> data_o == ~$past(data_o))
    else $error("data did not alternate");
  chk_one_low: assert property (busy_o |-> $onehot(~stb_o))
    else $error("strobe not walking zero");
  chk_stb_step: assert property (busy_o && $past(busy_o)
    && $changed(stb_o) |-> stb_o == {$past(stb_o[3:0]), $past(stb_o[4])})
    else $error("strobe step wrong");
  chk_fall_stable: assert property ($fell(link_clk_o) && busy_o
    |-> $stable(data_o) && $stable(stb_o)) else $error("word moved at fall");
  chk_stop_ends: assert property (busy_o && stop_i |-> ##[1:4] !busy_o)
    else $error("stop not obeyed");
  chk_idle_vals: assert property (!busy_o && !$past(busy_o)
    |-> stb_o == 5'h1F && data_o == 8'h00) else $error("idle value wrong");
endmodule
bind link_pattern_gen link_pattern_gen_chk u_chk (.clk_sys_i, .rst_n_i,
  .stop_i, .link_clk_o, .data_o, .addr_o, .stb_o, .busy_o);

// File: tb/link_rx_model.sv
/* receiving card: keeps every word with a strobe low seen at a falling link clock edge.
   assumes the link clock is still between runs. */
`timescale 1ns/1ps
`include "link_test_defines.svh"
// =====================================================
// receiver
module link_rx_model
  import link_test_pkg::*;
(
  input wire logic                 link_clk_i,
  input wire logic [`LT_BUS_W-1:0] data_i,
  input wire logic [`LT_BUS_W-1:0] addr_i,
  input wire logic [`LT_STB_W-1:0] stb_i
);
  link_word_s q[$];
  // falling edge keeps clear of the change just after the rise
  // no strobe low means no transfer, as at the cut end of a run
  always @(negedge link_clk_i) if (stb_i != `LT_STB_IDLE)
    q.push_back({data_i, addr_i, stb_i});
endmodule

// File: tb/link_pattern_gen_tb_top.sv
/* testbench of the pattern generator.
   assumes HALF_CYC of 2 and the receiver model beside it. */
`timescale 1ns/1ps
// =====================================================
// bench
module link_pattern_gen_tb_top;
  import link_test_pkg::*;
`define CMP(a, b) begin checks++; if ((a) !== (b)) begin err_total++; \
  $display("wrong value at %0t: %h %h", $time, a, b); end end
  logic clk_sys_i = 0, rst_n_i = 0, start_i = 0, repeat_i = 0, stop_i = 0;
  logic link_clk_o, busy_o;
  logic [7:0] data_o, addr_o;
  logic [4:0] stb_o;
  int err_total = 0, checks = 0;
  always #2.5 clk_sys_i = ~clk_sys_i;
  link_pattern_gen #(.HALF_CYC(2)) u_dut (.clk_sys_i, .rst_n_i, .start_i,
    .repeat_i, .stop_i, .link_clk_o, .data_o, .addr_o, .stb_o, .busy_o);
  link_rx_model u_rx (.link_clk_i(link_clk_o), .data_i(data_o),
    .addr_i(addr_o), .stb_i(stb_o));
  task automatic go(input logic rep);
    @(posedge clk_sys_i) start_i <= 1;
    repeat_i <= rep;
    u_rx.q.delete();
    @(posedge clk_sys_i) start_i <= 0;
    repeat (2) @(posedge clk_sys_i);
    #1 `CMP(busy_o, 1'b1)
  endtask
  task automatic seq_check(input int lo);
    link_word_s w, p;
    `CMP(u_rx.q.size() >= lo, 1'b1)
    `CMP(u_rx.q[0], {8'hAA, 8'hAA, 5'h1E})
    for (int i = 1; i < u_rx.q.size(); i++) begin
      w = u_rx.q[i];
      p = u_rx.q[i-1];
      `CMP(w.addr, w.data)
      `CMP(w.data, ~p.data)
      `CMP(w.stb, {p.stb[3:0], p.stb[4]})
      `CMP(w.data == 8'hAA || w.data == 8'h55, 1'b1)
    end
  endtask
  task automatic t_repeat;
    go(1'b1);
    // a second start mid-run must not restart the sweep
    for (int i = 0; i < 400 && u_rx.q.size() < 12; i++) begin
      @(posedge clk_sys_i) start_i <= (u_rx.q.size() == 4);
    end
    @(posedge clk_sys_i) start_i <= 0;
    stop_i <= 1;
    @(posedge clk_sys_i) stop_i <= 0;
    repeat (5) @(posedge clk_sys_i);
    #1 `CMP(busy_o, 1'b0)
    seq_check(12);
    `CMP(stb_o, 5'h1F)
  endtask
  task automatic t_single;
    go(1'b0);
    for (int i = 0; i < 200 && busy_o; i++) begin
      @(posedge clk_sys_i);
      #1;
    end
    #1 `CMP(busy_o, 1'b0)
    seq_check(5);
    `CMP(u_rx.q.size(), 5)
  endtask
  task automatic end_sim;
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    #100000;
    err_total++;
    end_sim();
  end
  initial begin
    repeat (20) @(posedge clk_sys_i);
    rst_n_i <= 1;
    t_repeat();
    t_single();
    end_sim();
  end
endmodule
